/* rtl/tbd_pkg.sv */
package tbd_pkg;
   // ****************************************
   // sizes
   // ****************************************
   localparam int NUM_MP = 2;
   localparam int MAX_RES = 4;
   localparam int NSLOT = NUM_MP * MAX_RES;
   localparam int SLOT_W = 3;
   localparam int RES_W = 2;
   localparam int MP_W = 1;
   localparam int WARP_SIZE = 8;
   localparam int LANE_W = 3;
   localparam int BDIM_W = 4;
   localparam int GDIM_W = 4;
   localparam int TID_W = 12;
   localparam int WIDX_W = TID_W - LANE_W;
   localparam int BID_W = 8;
   localparam int RPT_W = 6;
   localparam int REGP_W = 18;
   localparam int SMEM_W = 11;
   localparam int CNT_W = 7;
   localparam int ARR_W = 4;
   localparam int POS_W = RES_W + LANE_W;
   localparam int PROD_W = 21;
   localparam int ADDR_W = 8;
   localparam int SPC_W = 3;
   // ****************************************
   // capacities
   // ****************************************
   localparam logic [TID_W-1:0] MAX_THREADS = 12'h040;
   localparam logic [PROD_W-1:0] MP_REGS = 21'h000400;
   localparam logic [PROD_W-1:0] MP_SMEM = 21'h000400;
   localparam logic [LANE_W-1:0] HALF_LANE = 3'h4;
   localparam logic [SLOT_W-1:0] RES_MASK = 3'h3;
   // ****************************************
   // memory spaces
   // ****************************************
   localparam logic [SPC_W-1:0] SP_LOCAL = 3'h0;
   localparam logic [SPC_W-1:0] SP_GLOBAL = 3'h1;
   localparam logic [SPC_W-1:0] SP_SHARED = 3'h2;
   localparam logic [SPC_W-1:0] SP_CONST = 3'h3;
   localparam logic [SPC_W-1:0] SP_TEX = 3'h4;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CHECK = 2'b01,
      ST_ISSUE = 2'b10,
      ST_DRAIN = 2'b11
   } tbd_state_t;
endpackage

/* rtl/tbd_tid_map.sv */
`timescale 1ns/1ps
module tbd_tid_map
   import tbd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [BDIM_W-1:0] dx,
   input wire logic [BDIM_W-1:0] dy,
   input wire logic q_valid,
   input wire logic q_dim3,
   input wire logic [BDIM_W-1:0] q_x,
   input wire logic [BDIM_W-1:0] q_y,
   input wire logic [BDIM_W-1:0] q_z,
   output logic r_valid,
   output logic [TID_W-1:0] r_tid,
   output logic [WIDX_W-1:0] r_warp,
   output logic [LANE_W-1:0] r_lane,
   output logic r_half
);
   // ****************************************
   // linear id
   // ****************************************
   logic [TID_W-1:0] tid_nxt;
   logic [TID_W-1:0] zterm;
   always_comb begin
      zterm = TID_W'(q_z) * TID_W'(dx) * TID_W'(dy); // see (RULE_02)
      tid_nxt = TID_W'(q_x) + TID_W'(q_y) * TID_W'(dx); // see (RULE_01)
      if (q_dim3) begin
         tid_nxt = tid_nxt + zterm; // see (RULE_02)
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         r_valid <= 1'b0;
         r_tid <= '0;
         r_warp <= '0;
         r_lane <= '0;
         r_half <= 1'b0;
      end else begin
         r_valid <= q_valid;
         r_tid <= tid_nxt;
         // fixed split: warp w holds ids w*8 .. w*8+7
         r_warp <= tid_nxt[TID_W-1:LANE_W]; // see (RULE_05)
         r_lane <= tid_nxt[LANE_W-1:0]; // see (RULE_05)
         r_half <= tid_nxt[LANE_W-1]; // see (RULE_06)
      end
   end
   // ****************************************
   // checks
   // ****************************************
   tid_2d_a: assert property (@(posedge sys_clk) disable iff (!rstn) // see (RULE_01)
      q_valid && !q_dim3 |=> r_tid == TID_W'($past(q_x)) + TID_W'($past(q_y)) * TID_W'(dx))
      else $error("2d thread id wrong");
   tid_3d_a: assert property (@(posedge sys_clk) disable iff (!rstn) // see (RULE_02)
      q_valid && q_dim3 |=> r_tid == TID_W'($past(q_x)) + TID_W'($past(q_y)) * TID_W'(dx)
         + TID_W'($past(q_z)) * TID_W'(dx) * TID_W'(dy))
      else $error("3d thread id wrong");
   warp_split_a: assert property (@(posedge sys_clk) disable iff (!rstn) // see (RULE_05)
      r_valid |-> r_warp == WIDX_W'(r_tid / WARP_SIZE) && r_lane == LANE_W'(r_tid % WARP_SIZE))
      else $error("warp split not consecutive");
   half_warp_a: assert property (@(posedge sys_clk) disable iff (!rstn) // see (RULE_06)
      r_valid |-> r_half == (r_lane >= HALF_LANE))
      else $error("half warp wrong");
endmodule

/* rtl/tbd_dispatch.sv */
`timescale 1ns/1ps
// Functional notes
// (RULE_01) 2d thread id is x plus y*Dx
// (RULE_02) 3d id adds z*Dx*Dy
// (RULE_03) block id is bx plus by*grid x
// (RULE_04) barrier holds block until all arrive
// (RULE_05) warps hold consecutive ids from thread 0
// (RULE_06) half warp is lower or upper half
// (RULE_07) one instruction per warp, shared warp size
// (RULE_08) scheduler rotates among resident warps
// (RULE_09) block stays on one multiprocessor
// (RULE_10) too many registers fails the launch
// (RULE_11) several blocks share one multiprocessor
// (RULE_12) same-address warp write keeps one write
// (RULE_13) block order free, no inter-block sync
// (RULE_14) each processor owns 32-bit registers
// (RULE_15) local/global uncached, constant/texture cached
// (RULE_16) host writes spaces, device reads const/tex
// (RULE_17) launcher gives all blocks same shape
// (RULE_18) blocks run serially, parallel or mixed
// (RULE_19) issue only when block resources fit
// (RULE_20) barrier tracking cleared after release
module tbd_dispatch
   import tbd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic launch_valid,
   output logic launch_ready,
   input wire logic [GDIM_W-1:0] launch_gx,
   input wire logic [GDIM_W-1:0] launch_gy,
   input wire logic [BDIM_W-1:0] launch_dx,
   input wire logic [BDIM_W-1:0] launch_dy,
   input wire logic [BDIM_W-1:0] launch_dz,
   input wire logic launch_dim3,
   input wire logic [RPT_W-1:0] launch_regs,
   input wire logic [SMEM_W-1:0] launch_smem,
   output logic launch_fail,
   output logic launch_done,
   output logic issue_valid,
   output logic [SLOT_W-1:0] issue_slot,
   output logic [BID_W-1:0] issue_block_id,
   output logic [GDIM_W-1:0] issue_bx,
   output logic [GDIM_W-1:0] issue_by,
   input wire logic retire_valid,
   input wire logic [SLOT_W-1:0] retire_slot,
   output logic [NUM_MP-1:0] sched_valid,
   output logic [NUM_MP-1:0][RES_W-1:0] sched_slot,
   output logic [NUM_MP-1:0][LANE_W-1:0] sched_warp,
   output logic [NUM_MP-1:0][WARP_SIZE-1:0] sched_mask,
   input wire logic bar_arr_valid,
   input wire logic [SLOT_W-1:0] bar_arr_slot,
   input wire logic [ARR_W-1:0] bar_arr_count,
   output logic [NSLOT-1:0] bar_hold,
   output logic bar_release_valid,
   output logic [SLOT_W-1:0] bar_release_slot,
   input wire logic q_valid,
   input wire logic [BDIM_W-1:0] q_x,
   input wire logic [BDIM_W-1:0] q_y,
   input wire logic [BDIM_W-1:0] q_z,
   output logic r_valid,
   output logic [TID_W-1:0] r_tid,
   output logic [WIDX_W-1:0] r_warp,
   output logic [LANE_W-1:0] r_lane,
   output logic r_half,
   input wire logic [WARP_SIZE-1:0] wr_valid,
   input wire logic [WARP_SIZE-1:0][ADDR_W-1:0] wr_addr,
   output logic [WARP_SIZE-1:0] wr_commit,
   input wire logic acc_valid,
   input wire logic [SPC_W-1:0] acc_space,
   input wire logic acc_write,
   input wire logic acc_host,
   output logic acc_ans_valid,
   output logic acc_ok,
   output logic acc_cached
);
   // ****************************************
   // launch state
   // ****************************************
   tbd_state_t state_r;
   logic [GDIM_W-1:0] gx_r, gy_r, bx_r, by_r;
   logic [BDIM_W-1:0] dx_r, dy_r, dz_r;
   logic dim3_r;
   logic [RPT_W-1:0] regs_r;
   logic [SMEM_W-1:0] smem_r;
   logic [TID_W-1:0] threads_r;
   logic [REGP_W-1:0] blk_regs_r;
   logic [LANE_W:0] wpb_r;
   logic [NSLOT-1:0] slot_busy_r;
   logic [TID_W-1:0] threads_c;
   logic [REGP_W-1:0] blk_regs_c;
   logic bad_c;
   logic [NUM_MP-1:0] fit_c;
   logic [NUM_MP-1:0][RES_W-1:0] free_c;
   logic fit_any;
   logic [SLOT_W-1:0] pick_c;
   logic last_blk;
   assign launch_ready = (state_r == ST_IDLE);
   always_comb begin
      threads_c = TID_W'(dx_r) * TID_W'(dy_r);
      if (dim3_r) begin
         threads_c = TID_W'(threads_c * TID_W'(dz_r));
      end
      // each thread uses regs_r 32-bit registers of its processor
      blk_regs_c = REGP_W'(regs_r) * REGP_W'(threads_c); // see (RULE_14)
      bad_c = (PROD_W'(blk_regs_c) > MP_REGS) || (threads_c > MAX_THREADS) // see (RULE_10)
         || (threads_c == '0) || (PROD_W'(smem_r) > MP_SMEM)
         || (gx_r == '0) || (gy_r == '0);
   end
   // ****************************************
   // per multiprocessor capacity
   // ****************************************
   genvar m;
   generate
      for (m = 0; m < NUM_MP; m++) begin : g_mp
         logic [SLOT_W-1:0] cnt;
         logic [PROD_W-1:0] need_regs, need_smem;
         logic [POS_W-1:0] pos_r;
         logic [SLOT_W-1:0] gslot;
         logic pos_ok;
         always_comb begin
            cnt = '0;
            free_c[m] = '0;
            for (int s = MAX_RES - 1; s >= 0; s--) begin
               if (slot_busy_r[m * MAX_RES + s]) begin
                  cnt = SLOT_W'(cnt + 1'b1);
               end else begin
                  free_c[m] = RES_W'(s);
               end
            end
            // resources shared out among all resident blocks
            need_regs = PROD_W'(cnt + 1'b1) * PROD_W'(blk_regs_r); // see (RULE_11)
            need_smem = PROD_W'(cnt + 1'b1) * PROD_W'(smem_r); // see (RULE_11)
            fit_c[m] = (cnt < SLOT_W'(MAX_RES)) && (need_regs <= MP_REGS) // see (RULE_19)
               && (need_smem <= MP_SMEM);
         end
         // rotating pointer over slot and warp positions
         assign gslot = SLOT_W'(m * MAX_RES) + SLOT_W'(pos_r[POS_W-1:LANE_W]);
         assign pos_ok = slot_busy_r[gslot] && ({1'b0, pos_r[LANE_W-1:0]} < wpb_r)
            && !bar_hold[gslot];
         always_ff @(posedge sys_clk) begin
            if (!rstn) begin
               pos_r <= '0;
               sched_valid[m] <= 1'b0;
               sched_slot[m] <= '0;
               sched_warp[m] <= '0;
               sched_mask[m] <= '0;
            end else begin
               pos_r <= POS_W'(pos_r + 1'b1); // see (RULE_08)
               sched_valid[m] <= pos_ok; // see (RULE_08)
               sched_slot[m] <= pos_r[POS_W-1:LANE_W];
               sched_warp[m] <= pos_r[LANE_W-1:0];
               // all lanes of a warp run one instruction; short tail warp masks lanes
               sched_mask[m] <= {WARP_SIZE{1'b1}}; // see (RULE_07)
               if (({1'b0, pos_r[LANE_W-1:0]} == (LANE_W + 1)'(wpb_r - 1'b1))
                  && (threads_r[LANE_W-1:0] != '0)) begin
                  sched_mask[m] <= WARP_SIZE'((1 << threads_r[LANE_W-1:0]) - 1); // see (RULE_07)
               end
            end
         end
      end
   endgenerate
   always_comb begin
      fit_any = 1'b0;
      pick_c = '0;
      // lowest fitting multiprocessor; order across blocks carries no meaning
      for (int i = NUM_MP - 1; i >= 0; i--) begin
         if (fit_c[i]) begin
            fit_any = 1'b1;
            pick_c = SLOT_W'(i * MAX_RES) + SLOT_W'(free_c[i]); // see (RULE_13)
         end
      end
   end
   assign last_blk = (bx_r == GDIM_W'(gx_r - 1'b1)) && (by_r == GDIM_W'(gy_r - 1'b1));
   // ****************************************
   // dispatch sequence
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         gx_r <= '0;
         gy_r <= '0;
         dx_r <= '0;
         dy_r <= '0;
         dz_r <= '0;
         dim3_r <= 1'b0;
         regs_r <= '0;
         smem_r <= '0;
         threads_r <= '0;
         blk_regs_r <= '0;
         wpb_r <= '0;
         bx_r <= '0;
         by_r <= '0;
         launch_fail <= 1'b0;
         launch_done <= 1'b0;
         issue_valid <= 1'b0;
         issue_slot <= '0;
         issue_block_id <= '0;
         issue_bx <= '0;
         issue_by <= '0;
      end else begin
         launch_fail <= 1'b0;
         launch_done <= 1'b0;
         issue_valid <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (launch_valid) begin
                  // one shape for every block of the grid
                  gx_r <= launch_gx; // see (RULE_17)
                  gy_r <= launch_gy;
                  dx_r <= launch_dx;
                  dy_r <= launch_dy;
                  dz_r <= launch_dz;
                  dim3_r <= launch_dim3;
                  regs_r <= launch_regs;
                  smem_r <= launch_smem;
                  state_r <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               threads_r <= threads_c;
               blk_regs_r <= blk_regs_c;
               wpb_r <= (LANE_W + 1)'((threads_c + TID_W'(WARP_SIZE - 1)) >> LANE_W);
               bx_r <= '0;
               by_r <= '0;
               if (bad_c) begin
                  launch_fail <= 1'b1; // see (RULE_10)
                  state_r <= ST_IDLE;
               end else begin
                  state_r <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               // issues whenever room exists: serial, parallel or both
               if (fit_any) begin // see (RULE_18)
                  issue_valid <= 1'b1;
                  issue_slot <= pick_c; // see (RULE_09)
                  issue_bx <= bx_r;
                  issue_by <= by_r;
                  issue_block_id <= BID_W'(bx_r) + BID_W'(by_r) * BID_W'(gx_r); // see (RULE_03)
                  if (last_blk) begin
                     state_r <= ST_DRAIN;
                  end else if (bx_r == GDIM_W'(gx_r - 1'b1)) begin
                     bx_r <= '0;
                     by_r <= GDIM_W'(by_r + 1'b1);
                  end else begin
                     bx_r <= GDIM_W'(bx_r + 1'b1);
                  end
               end
            end
            ST_DRAIN: begin
               if (slot_busy_r == '0 && !issue_valid) begin
                  launch_done <= 1'b1;
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
   // slot stays with its multiprocessor from issue until retire
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         slot_busy_r <= '0;
      end else begin
         for (int s = 0; s < NSLOT; s++) begin
            if (state_r == ST_ISSUE && fit_any && pick_c == SLOT_W'(s)) begin
               slot_busy_r[s] <= 1'b1; // see (RULE_09)
            end else if (retire_valid && retire_slot == SLOT_W'(s)) begin
               slot_busy_r[s] <= 1'b0;
            end
         end
      end
   end
   // ****************************************
   // barrier, one counter per resident block
   // ****************************************
   logic [NSLOT-1:0][CNT_W-1:0] bar_cnt_r;
   logic [NSLOT-1:0] bar_full_c;
   genvar b;
   generate
      for (b = 0; b < NSLOT; b++) begin : g_bar
         logic [CNT_W-1:0] sum;
         logic hit;
         assign hit = bar_arr_valid && (bar_arr_slot == SLOT_W'(b));
         assign sum = CNT_W'(bar_cnt_r[b] + CNT_W'(bar_arr_count));
         assign bar_full_c[b] = hit && (TID_W'(sum) >= threads_r);
         always_ff @(posedge sys_clk) begin
            if (!rstn) begin
               bar_cnt_r[b] <= '0;
               bar_hold[b] <= 1'b0;
            end else if (bar_full_c[b] || (retire_valid && retire_slot == SLOT_W'(b))) begin
               bar_cnt_r[b] <= '0; // see (RULE_20)
               bar_hold[b] <= 1'b0; // see (RULE_04)
            end else if (hit) begin
               bar_cnt_r[b] <= sum;
               bar_hold[b] <= 1'b1; // see (RULE_04)
            end
         end
      end
   endgenerate
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         bar_release_valid <= 1'b0;
         bar_release_slot <= '0;
      end else begin
         bar_release_valid <= |bar_full_c; // see (RULE_04)
         bar_release_slot <= bar_arr_slot;
      end
   end
   // ****************************************
   // same-address writes: highest lane wins
   // ****************************************
   genvar l;
   generate
      for (l = 0; l < WARP_SIZE; l++) begin : g_lane
         logic beaten;
         always_comb begin
            beaten = 1'b0;
            for (int j = l + 1; j < WARP_SIZE; j++) begin
               if (wr_valid[j] && wr_addr[j] == wr_addr[l]) begin
                  beaten = 1'b1;
               end
            end
         end
         always_ff @(posedge sys_clk) begin
            if (!rstn) begin
               wr_commit[l] <= 1'b0;
            end else begin
               wr_commit[l] <= wr_valid[l] && !beaten; // see (RULE_12)
            end
         end
      end
   endgenerate
   // ****************************************
   // memory space access check
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         acc_ans_valid <= 1'b0;
         acc_ok <= 1'b0;
         acc_cached <= 1'b0;
      end else begin
         acc_ans_valid <= acc_valid;
         acc_ok <= !(acc_write && !acc_host // see (RULE_16)
            && (acc_space == SP_CONST || acc_space == SP_TEX));
         acc_cached <= (acc_space == SP_CONST || acc_space == SP_TEX); // see (RULE_15)
      end
   end
   tbd_tid_map u_tid (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .dx(dx_r),
      .dy(dy_r),
      .q_valid(q_valid),
      .q_dim3(dim3_r),
      .q_x(q_x),
      .q_y(q_y),
      .q_z(q_z),
      .r_valid(r_valid),
      .r_tid(r_tid),
      .r_warp(r_warp),
      .r_lane(r_lane),
      .r_half(r_half)
   );
   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic busy_at_issue;
   assign busy_at_issue = slot_busy_r[issue_slot];
   // occupancy as the scheduler saw it one cycle before its output
   logic [NSLOT-1:0] busy_d_r;
   always_ff @(posedge sys_clk) begin
      busy_d_r <= slot_busy_r;
   end
   blk_id_a: assert property (issue_valid |-> issue_block_id == // see (RULE_03)
      BID_W'(issue_bx) + BID_W'(issue_by) * BID_W'(gx_r))
      else $error("block id wrong");
   reg_fail_a: assert property (state_r == ST_CHECK && PROD_W'(blk_regs_c) > MP_REGS // see (RULE_10)
      |=> launch_fail && state_r == ST_IDLE)
      else $error("oversized block not refused");
   issue_fit_a: assert property (issue_valid |-> $past(fit_any)) // see (RULE_19)
      else $error("issue without room");
   one_mp_a: assert property (issue_valid |-> busy_at_issue) // see (RULE_09)
      else $error("issued slot not held");
   bar_rel_a: assert property (bar_arr_valid && bar_full_c[bar_arr_slot] // see (RULE_04)
      |=> bar_release_valid && bar_release_slot == $past(bar_arr_slot))
      else $error("barrier not released");
   bar_clr_a: assert property (bar_release_valid |-> bar_cnt_r[bar_release_slot] == '0 // see (RULE_20)
      && !bar_hold[bar_release_slot])
      else $error("barrier tracking not cleared");
   wr_one_a: assert property (wr_valid != '0 |=> wr_commit != '0) // see (RULE_12)
      else $error("no write kept");
   sched_ok_a: assert property (sched_valid[0] |-> busy_d_r[sched_slot[0]] // see (RULE_08)
      && {1'b0, sched_warp[0]} < wpb_r)
      else $error("scheduled warp not resident");
   const_wr_a: assert property (acc_valid && acc_write && !acc_host // see (RULE_16)
      && acc_space == SP_CONST |=> !acc_ok)
      else $error("device const write accepted");
   done_c: cover property (launch_done);
   fail_c: cover property (launch_fail);
   bar_c: cover property (bar_release_valid);
   multi_c: cover property (slot_busy_r[1:0] == 2'b11);
endmodule

/* dv/tbd_host.sv */
`timescale 1ns/1ps
module tbd_host
   import tbd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic launch_ready,
   output logic launch_valid,
   output logic [GDIM_W-1:0] launch_gx,
   output logic [GDIM_W-1:0] launch_gy,
   output logic [BDIM_W-1:0] launch_dx,
   output logic [BDIM_W-1:0] launch_dy,
   output logic [BDIM_W-1:0] launch_dz,
   output logic launch_dim3,
   output logic [RPT_W-1:0] launch_regs,
   output logic [SMEM_W-1:0] launch_smem
);
   // ****************************************
   // launch request
   // ****************************************
   logic [37:0] shape_r = 38'h0;
   initial launch_valid = 1'b0;
   assign {launch_gx, launch_gy, launch_dx, launch_dy, launch_dz, launch_dim3, launch_regs,
      launch_smem} = shape_r;
   // one request carries the single shape of every block in the grid
   task automatic launch(input logic [37:0] s);
      launch_valid = 1'b1;
      shape_r = s;
      while (launch_ready !== 1'b1) begin
         @(posedge sys_clk);
         #1;
      end
      @(posedge sys_clk);
      #1;
      launch_valid = 1'b0;
      // released lines must not keep showing the taken shape
      shape_r = ~s;
   endtask
endmodule

/* dv/tb_thread_block_warp_dispatch.sv */
`timescale 1ns/1ps
module tb_thread_block_warp_dispatch
   import tbd_pkg::*;
;
   // ****************************************
   // signals and instances
   // ****************************************
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic launch_valid, launch_ready, launch_dim3, launch_fail, launch_done, issue_valid;
   logic [GDIM_W-1:0] launch_gx, launch_gy, issue_bx, issue_by;
   logic [BDIM_W-1:0] launch_dx, launch_dy, launch_dz;
   logic [RPT_W-1:0] launch_regs;
   logic [SMEM_W-1:0] launch_smem;
   logic [SLOT_W-1:0] issue_slot, bar_release_slot;
   logic [BID_W-1:0] issue_block_id;
   logic retire_valid = 1'b0;
   logic bar_arr_valid = 1'b0;
   logic q_valid = 1'b0;
   logic [SLOT_W-1:0] retire_slot = 3'h0;
   logic [SLOT_W-1:0] bar_arr_slot = 3'h0;
   logic [ARR_W-1:0] bar_arr_count = 4'h0;
   logic [NSLOT-1:0] bar_hold;
   logic bar_release_valid, r_valid, r_half;
   logic [BDIM_W-1:0] q_x = 4'h0, q_y = 4'h0, q_z = 4'h0;
   logic [TID_W-1:0] r_tid;
   logic [WIDX_W-1:0] r_warp;
   logic [LANE_W-1:0] r_lane;
   logic [WARP_SIZE-1:0] wr_valid = 8'h00, wr_commit;
   logic [WARP_SIZE-1:0][ADDR_W-1:0] wr_addr = '0;
   logic acc_valid = 1'b0, acc_write = 1'b0, acc_host = 1'b0;
   logic [SPC_W-1:0] acc_space = 3'h0;
   logic acc_ans_valid, acc_ok, acc_cached;
   logic [NUM_MP-1:0] sched_valid;
   logic [NUM_MP-1:0][RES_W-1:0] sched_slot;
   logic [NUM_MP-1:0][LANE_W-1:0] sched_warp;
   logic [NUM_MP-1:0][WARP_SIZE-1:0] sched_mask;
   int failures = 0;
   int checked = 0;
   logic [18:0] iss[$];
   tbd_dispatch dut (.sys_clk, .rstn, .launch_valid, .launch_ready, .launch_gx, .launch_gy,
      .launch_dx, .launch_dy, .launch_dz, .launch_dim3, .launch_regs, .launch_smem, .launch_fail,
      .launch_done, .issue_valid, .issue_slot, .issue_block_id, .issue_bx, .issue_by,
      .retire_valid, .retire_slot, .sched_valid, .sched_slot, .sched_warp, .sched_mask,
      .bar_arr_valid, .bar_arr_slot, .bar_arr_count, .bar_hold, .bar_release_valid,
      .bar_release_slot, .q_valid, .q_x, .q_y, .q_z, .r_valid, .r_tid, .r_warp, .r_lane,
      .r_half, .wr_valid, .wr_addr, .wr_commit, .acc_valid, .acc_space, .acc_write, .acc_host,
      .acc_ans_valid, .acc_ok, .acc_cached);
   tbd_host host (.sys_clk, .launch_ready, .launch_valid, .launch_gx, .launch_gy, .launch_dx,
      .launch_dy, .launch_dz, .launch_dim3, .launch_regs, .launch_smem);
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (issue_valid === 1'b1)
         iss.push_back({issue_slot, issue_block_id, issue_bx, issue_by});
   end
   task automatic tick(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wait_iss(input int n);
      repeat (40) if (iss.size() < n) tick();
   endtask
   task automatic retire(input logic [SLOT_W-1:0] s);
      retire_valid = 1'b1;
      retire_slot = s;
      tick();
      retire_valid = 1'b0;
      tick();
   endtask
   task automatic wait_done();
      for (int k = 0; k < 20 && launch_done !== 1'b1; k++) tick();
      chk(launch_done, 1'b1);
   endtask
   task automatic tid_q(input logic [3:0] x, y, z, input logic [11:0] dx, dxy);
      logic [TID_W-1:0] t;
      t = 12'(x) + 12'(y) * dx + 12'(z) * dxy;
      q_valid = 1'b1;
      q_x = x;
      q_y = y;
      q_z = z;
      tick();
      q_valid = 1'b0;
      chk(r_valid, 1'b1);
      chk(r_tid, t);
      chk(r_warp, t[TID_W-1:3]);
      chk(r_lane, t[2:0]);
      chk(r_half, t[2]);
      tick();
   endtask
   task automatic arrive(input logic [3:0] n, input logic rel);
      bar_arr_valid = 1'b1;
      bar_arr_count = n;
      tick();
      bar_arr_valid = 1'b0;
      chk(bar_release_valid, rel);
      chk(bar_hold[0], !rel);
      if (rel) chk(bar_release_slot, 3'h0);
      tick();
   endtask
   task automatic acc(input logic [2:0] s, input logic w, h);
      acc_valid = 1'b1;
      acc_space = s;
      acc_write = w;
      acc_host = h;
      tick();
      acc_valid = 1'b0;
      chk(acc_ans_valid, 1'b1);
      chk(acc_ok, !(w && !h && s >= SP_CONST));
      if (!h) chk(acc_cached, s >= SP_CONST);
      tick();
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   // 2x2 grid of 3x2x2 blocks, all four fit side by side on mp 0
   task automatic grid_order();
      iss.delete();
      host.launch({4'h2, 4'h2, 4'h3, 4'h2, 4'h2, 1'b1, 6'h04, 11'h010});
      tick(3);
      chk(issue_valid, 1'b1);
      wait_iss(4);
      chk(iss.size(), 4);
      for (int i = 0; i < 4; i++)
         chk(iss[i], {3'(i), 8'(i), 4'(i % 2), 4'(i / 2)});
      // 12 threads: warp 1 is the tail warp with lanes 0..3 only, mp 1 stays idle
      for (int k = 0; k < 40; k++)
         if (!(sched_valid[0] === 1'b1 && sched_slot[0] == 2'h0 && sched_warp[0] == 3'h1)) tick();
      chk({sched_valid, sched_slot[0], sched_warp[0], sched_mask[0]},
         {2'b01, 2'h0, 3'h1, 8'h0f});
   endtask
   // each 8x8 block uses the whole register file, so one block per mp
   task automatic stall_grid();
      iss.delete();
      host.launch({4'h3, 4'h1, 4'h8, 4'h8, 4'h1, 1'b0, 6'h10, 11'h010});
      wait_iss(2);
      tick(10);
      chk(iss.size(), 2);
      chk(iss[1], {3'h4, 8'h01, 4'h1, 4'h0});
      tid_q(4'h5, 4'h3, 4'h7, 12'h008, 12'h000);
      retire(3'h0);
      wait_iss(3);
      chk(iss[2], {3'h0, 8'h02, 4'h2, 4'h0});
      retire(3'h4);
      retire(3'h0);
      wait_done();
   endtask
   task automatic fail_launch();
      host.launch({4'h1, 4'h1, 4'h8, 4'h8, 4'h1, 1'b0, 6'h3f, 11'h010});
      chk(launch_fail, 1'b0);
      tick();
      chk(launch_fail, 1'b1);
      chk(launch_ready, 1'b1);
      tick();
      chk(issue_valid, 1'b0);
   endtask
   initial begin
      tick(3);
      rstn = 1'b1;
      grid_order();
      tid_q(4'h2, 4'h1, 4'h1, 12'h003, 12'h006);
      tid_q(4'h2, 4'h1, 4'h0, 12'h003, 12'h006);
      arrive(4'h5, 1'b0);
      arrive(4'h7, 1'b1);
      arrive(4'h5, 1'b0);
      arrive(4'h7, 1'b1);
      wr_addr[1] = 8'h40;
      wr_addr[5] = 8'h40;
      wr_addr[2] = 8'h41;
      wr_valid = 8'h26;
      tick();
      wr_valid = 8'h00;
      chk(wr_commit, 8'h24);
      for (int s = 0; s < 5; s++) acc(3'(s), 1'b1, 1'b0);
      acc(SP_CONST, 1'b1, 1'b1);
      for (int i = 0; i < 4; i++) retire(3'(i));
      wait_done();
      stall_grid();
      fail_launch();
      give_verdict();
   end
   initial begin
      #100000;
      failures++;
      give_verdict();
   end
endmodule
